/* hw/nco_pll_regs_pkg.sv */
// Package for the oscillator frequency and clock multiplier register bank.
// Assumes an APB slave, 32-bit data, register index times four as byte address.
// Operation
// - AB frequency word, signed, halves 0x14/0x15
// - CD frequency word, signed, halves 0x16/0x17
// - Bit 12 holds loop filter at zero
// - Bit 11 lets SYNC align N dividers
// - Bit 10 runs PLL, zero bypasses it
// - Pump field: none, single, unused, dual
// - Prescaler codes 2 to 7, 000 eight
// - Bits 2:0 read back loop filter voltage
// - M bit7 low: divide by M[6:0]
// - M bit7 high: divide by twice M[6:0]
// - N divider divides by code plus one
package nco_pll_regs_pkg;

  // Register indices as printed; byte address is index times four
  localparam logic [7:0] IDX_AB_LOW = 8'h14;
  localparam logic [7:0] IDX_AB_HIGH = 8'h15;
  localparam logic [7:0] IDX_CD_LOW = 8'h16;
  localparam logic [7:0] IDX_CD_HIGH = 8'h17;
  localparam logic [7:0] IDX_PLL_CONTROL = 8'h18;
  localparam logic [7:0] IDX_PLL_DIVIDER = 8'h19;

  // Values after reset
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [15:0] PLL_CONTROL_RESET = 16'h2808;
  localparam logic [15:0] PLL_DIVIDER_RESET = 16'h0440;
  localparam logic [2:0] LF_VOLT_RESET = 3'h0;

  // Control field positions
  localparam int CTL_LPF_HOLD_BIT = 12;
  localparam int CTL_NDIV_SYNC_BIT = 11;
  localparam int CTL_PLL_RUN_BIT = 10;
  localparam int CTL_PUMP_MSB = 7;
  localparam int CTL_PUMP_LSB = 6;
  localparam int CTL_PRESCALE_MSB = 5;
  localparam int CTL_PRESCALE_LSB = 3;
  localparam int CTL_LF_VOLT_MSB = 2;

  // Divider field positions
  localparam int DIV_M_MSB = 15;
  localparam int DIV_M_LSB = 8;
  localparam int DIV_N_MSB = 7;
  localparam int DIV_N_LSB = 4;
  localparam int DIV_BIAS_MSB = 3;
  localparam int DIV_BIAS_LSB = 2;

  // Charge pump codes
  localparam logic [1:0] PUMP_NONE = 2'h0;
  localparam logic [1:0] PUMP_SINGLE = 2'h1;
  localparam logic [1:0] PUMP_DUAL = 2'h3;

  // Prescaler code that stands for divide by eight
  localparam logic [2:0] PRESCALE_EIGHT_CODE = 3'h0;
  localparam logic [3:0] PRESCALE_EIGHT = 4'h8;

  // Smallest valid direct M ratio
  localparam logic [6:0] M_DIRECT_MIN = 7'h04;

  // Input filter depth for pins from outside the pclk domain
  localparam int SYNC_STAGES = 3;

  // Decoded settings for the clock multiplier
  typedef struct packed {
    logic lpf_hold;
    logic pll_run;
    logic pll_bypass;
    logic pump_single;
    logic pump_dual;
    logic pump_code_unused;
    logic [3:0] prescale_ratio;
    logic prescale_code_unused;
    logic [7:0] m_ratio;
    logic m_invalid;
    logic [4:0] n_ratio;
    logic [1:0] vco_bias;
  } pll_cfg_t;

endpackage

/* hw/pin_filter.sv */
// Input filter for levels arriving from outside the pclk domain.
// Assumes each bit changes slowly compared to pclk; bits are filtered alone.
`timescale 1ns/100ps
module pin_filter
  import nco_pll_regs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw and filtered level
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  // First stage only feeds the second, to contain metastability
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end
    else
    begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (agree & stage3) | (~agree & level);
    end
  end

endmodule

/* hw/nco_pll_regs.sv */
// Oscillator frequency words and clock multiplier control registers.
// Assumes an APB3 master on pclk; loop filter code and SYNC are async pins.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module nco_pll_regs
  import nco_pll_regs_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog and pin inputs
  input wire logic [2:0] lf_volt_pin,
  input wire logic sync_pin,
  // Oscillator frequency words
  output logic [31:0] ab_freq_word,
  output logic [31:0] cd_freq_word,
  // Clock multiplier control
  output pll_cfg_t pll_cfg,
  output logic ndiv_sync
);

  logic [15:0] pll_control;
  logic [15:0] pll_divider_setup;
  logic [2:0] lf_volt;
  logic sync_level;
  logic sync_prev;

  // Index from a byte address; low two bits must be zero to hit a register
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] shifted;
    shifted = addr >> 2;
    return shifted[7:0];
  endfunction

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'h0) && (word_index(addr) == idx);
  endfunction

  // Prescaler ratio; code 001 is undocumented and passed through as one
  function automatic logic [3:0] prescale_ratio(input logic [2:0] code);
    logic [3:0] ratio;
    ratio = (code == PRESCALE_EIGHT_CODE) ? PRESCALE_EIGHT : {1'b0, code};
    return ratio;
  endfunction

  // M ratio: direct or doubled lower seven bits
  function automatic logic [7:0] m_ratio(input logic [7:0] m);
    logic [7:0] ratio;
    ratio = m[7] ? {m[6:0], 1'b0} : {1'b0, m[6:0]};
    return ratio;
  endfunction

  function automatic logic m_invalid(input logic [7:0] m);
    logic bad;
    bad = m[7] ? (m[6:0] < M_DIRECT_MIN[6:0]) : (m[6:0] < M_DIRECT_MIN);
    return bad;
  endfunction

  // Filtered pin inputs
  pin_filter #(.WIDTH(3)) lf_volt_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw(lf_volt_pin),
    .level(lf_volt)
  );

  pin_filter #(.WIDTH(1)) sync_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw(sync_pin),
    .level(sync_level)
  );

  // Address decode
  wire hit_ab_low = hits(paddr, IDX_AB_LOW);
  wire hit_ab_high = hits(paddr, IDX_AB_HIGH);
  wire hit_cd_low = hits(paddr, IDX_CD_LOW);
  wire hit_cd_high = hits(paddr, IDX_CD_HIGH);
  wire hit_control = hits(paddr, IDX_PLL_CONTROL);
  wire hit_divider = hits(paddr, IDX_PLL_DIVIDER);
  wire hit_any = hit_ab_low | hit_ab_high | hit_cd_low | hit_cd_high |
    hit_control | hit_divider;

  // Phases: answer is ready one cycle after setup, so every access has zero waits
  wire setup_phase = psel & ~penable;
  wire write_done = psel & penable & pready & pwrite & hit_any;

  // Control register reads back live loop filter code in its low bits
  wire [15:0] control_view = {pll_control[15:CTL_LF_VOLT_MSB+1], lf_volt};

  logic [15:0] read_word;
  always_comb
  begin
    read_word = 16'h0000;
    if (hit_ab_low)
      read_word = ab_freq_word[15:0];
    else if (hit_ab_high)
      read_word = ab_freq_word[31:16];
    else if (hit_cd_low)
      read_word = cd_freq_word[15:0];
    else if (hit_cd_high)
      read_word = cd_freq_word[31:16];
    else if (hit_control)
      read_word = control_view;
    else if (hit_divider)
      read_word = pll_divider_setup;
  end

  // Next values of the stored registers
  wire [15:0] wdata = pwdata[15:0];
  wire [31:0] next_ab = {hit_ab_high ? wdata : ab_freq_word[31:16],
    hit_ab_low ? wdata : ab_freq_word[15:0]};
  wire [31:0] next_cd = {hit_cd_high ? wdata : cd_freq_word[31:16],
    hit_cd_low ? wdata : cd_freq_word[15:0]};
  wire [15:0] next_control = {wdata[15:CTL_LF_VOLT_MSB+1], LF_VOLT_RESET};

  // Decoded clock multiplier settings, taken from the stored fields
  wire [1:0] pump_code = pll_control[CTL_PUMP_MSB:CTL_PUMP_LSB];
  wire [2:0] prescale_code = pll_control[CTL_PRESCALE_MSB:CTL_PRESCALE_LSB];
  wire [7:0] m_code = pll_divider_setup[DIV_M_MSB:DIV_M_LSB];
  wire [3:0] n_code = pll_divider_setup[DIV_N_MSB:DIV_N_LSB];

  pll_cfg_t next_pll_cfg;
  always_comb
  begin
    next_pll_cfg.lpf_hold = pll_control[CTL_LPF_HOLD_BIT];
    next_pll_cfg.pll_run = pll_control[CTL_PLL_RUN_BIT];
    next_pll_cfg.pll_bypass = ~pll_control[CTL_PLL_RUN_BIT];
    next_pll_cfg.pump_single = (pump_code == PUMP_SINGLE);
    next_pll_cfg.pump_dual = (pump_code == PUMP_DUAL);
    next_pll_cfg.pump_code_unused = (pump_code != PUMP_NONE) &&
      (pump_code != PUMP_SINGLE) && (pump_code != PUMP_DUAL);
    next_pll_cfg.prescale_ratio = prescale_ratio(prescale_code);
    next_pll_cfg.prescale_code_unused = (prescale_code == 3'h1);
    next_pll_cfg.m_ratio = m_ratio(m_code);
    next_pll_cfg.m_invalid = m_invalid(m_code);
    next_pll_cfg.n_ratio = {1'b0, n_code} + 5'h01;
    next_pll_cfg.vco_bias = pll_divider_setup[DIV_BIAS_MSB:DIV_BIAS_LSB];
  end

  // A SYNC rising edge aligns the N dividers only while enabled
  wire next_ndiv_sync = sync_level & ~sync_prev & pll_control[CTL_NDIV_SYNC_BIT];

  // APB answer, loaded during setup so that it stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      prdata <= (setup_phase & ~pwrite) ? {16'h0000, read_word} : 32'h0000_0000;
    end
  end

  // Frequency words; a half write changes only that half
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_freq_word <= FREQ_RESET;
      cd_freq_word <= FREQ_RESET;
    end
    else if (write_done)
    begin
      ab_freq_word <= next_ab;
      cd_freq_word <= next_cd;
    end
  end

  // Control and divider registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_control <= PLL_CONTROL_RESET;
      pll_divider_setup <= PLL_DIVIDER_RESET;
    end
    else
    begin
      if (write_done & hit_control)
        pll_control <= next_control;
      if (write_done & hit_divider)
        pll_divider_setup <= wdata;
    end
  end

  // Registered outputs; settings follow a write by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_cfg <= '0;
      sync_prev <= 1'b0;
      ndiv_sync <= 1'b0;
    end
    else
    begin
      pll_cfg <= next_pll_cfg;
      sync_prev <= sync_level;
      ndiv_sync <= next_ndiv_sync;
    end
  end

endmodule

/* verification/nco_pll_regs_props.sv */
// Checker for the register bank ports.
// Assumes a one-cycle APB answer and byte addresses 0x50 to 0x64.
`timescale 1ns/100ps
module nco_pll_regs_chk
  import nco_pll_regs_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs
  input wire logic [2:0] lf_volt_pin,
  input wire logic sync_pin,
  input wire logic [31:0] ab_freq_word,
  input wire logic [31:0] cd_freq_word,
  input wire pll_cfg_t pll_cfg,
  input wire logic ndiv_sync
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_done = psel && penable && pwrite && pready && !pslverr;
  wire wr_ctl = wr_done && paddr == 8'h60;
  AST_ANSWER: assert property (psel && !penable |=> pready) else $error("no answer");
  AST_QUIET: assert property (!psel |=> !pready) else $error("stray ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
  AST_AB_LOW: assert property (wr_done && paddr == 8'h50 |=>
    ab_freq_word[15:0] == $past(pwdata[15:0])) else $error("ab low half");
  AST_CD_HIGH: assert property (wr_done && paddr == 8'h5C |=>
    cd_freq_word[31:16] == $past(pwdata[15:0])) else $error("cd high half");
  AST_HOLD: assert property (wr_ctl |=> ##1
    pll_cfg.lpf_hold == $past(pwdata[12], 2)) else $error("hold bit");
  AST_RUN: assert property (wr_ctl |=> ##1 pll_cfg.pll_run != pll_cfg.pll_bypass
    && pll_cfg.pll_run == $past(pwdata[10], 2)) else $error("run bit");
  AST_PUMP: assert property (wr_ctl |=> ##1
    pll_cfg.pump_dual == ($past(pwdata[7:6], 2) == 2'b11)) else $error("pump");
  AST_NDIV: assert property (wr_done && paddr == 8'h64 |=> ##1
    pll_cfg.n_ratio == 5'($past(pwdata[7:4], 2)) + 5'd1) else $error("n ratio");
  AST_PULSE: assert property (ndiv_sync |=> !ndiv_sync) else $error("sync pulse");
endmodule

/* verification/tb.sv */
// Self-checking bench for the register bank.
// Assumes the APB slave answers at once and pins settle within a few cycles.
`timescale 1ns/100ps
module tb;
  import nco_pll_regs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sync_pin, pready, pslverr, ndiv_sync, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ab_freq_word, cd_freq_word, rd;
  logic [2:0] lf_volt_pin;
  pll_cfg_t pll_cfg;
  int miscompares, check_count;
  nco_pll_regs #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lf_volt_pin(lf_volt_pin), .sync_pin(sync_pin),
    .ab_freq_word(ab_freq_word), .cd_freq_word(cd_freq_word), .pll_cfg(pll_cfg),
    .ndiv_sync(ndiv_sync));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // A slave that never answers must fail the run, not slip through
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: no pready within 20 cycles", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic pll_cfg_t expc(input logic [15:0] c, input logic [15:0] m);
    pll_cfg_t e;
    e.lpf_hold = c[12];
    e.pll_run = c[10];
    e.pll_bypass = !c[10];
    e.pump_single = c[7:6] == 2'h1;
    e.pump_dual = c[7:6] == 2'h3;
    e.pump_code_unused = c[7:6] == 2'h2;
    e.prescale_ratio = c[5:3] == 3'h0 ? 4'h8 : {1'b0, c[5:3]};
    e.prescale_code_unused = c[5:3] == 3'h1;
    e.m_ratio = m[15] ? {m[14:8], 1'b0} : {1'b0, m[14:8]};
    e.m_invalid = m[14:8] < 7'h04;
    e.n_ratio = 5'(m[7:4]) + 5'h01;
    e.vco_bias = m[3:2];
    return e;
  endfunction
  // Writes both control words, then checks decode and readback
  task automatic cfg(input logic [15:0] c, input logic [15:0] m);
    apb(1'b1, 8'h60, {16'hA5A5, c});
    apb(1'b1, 8'h64, {16'h5A5A, m});
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(pll_cfg), 32'(expc(c, m)));
    apb(1'b0, 8'h60, 32'h0);
    chk(rd, {16'h0, c[15:3], 3'h5});
    apb(1'b0, 8'h64, 32'h0);
    chk(rd, {16'h0, m});
  endtask
  task automatic test_reset;
    #1;
    chk(32'(pll_cfg), 32'(expc(16'h2808, 16'h0440)));
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(8'h50 + 4 * i), 32'h0);
      chk(rd, i < 4 ? 32'h0 : (i == 4 ? 32'h280D : 32'h0440));
    end
    $display("test_reset done");
  endtask
  task automatic test_freq;
    logic [15:0] v [4] = '{16'h1234, 16'h8765, 16'hFEDC, 16'h0001};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'(8'h50 + 4 * i), {16'hFFFF, v[i]});
      @(posedge pclk);
      #1;
      chk(i < 2 ? ab_freq_word : cd_freq_word, i % 2 ? {v[i], v[i-1]} : {16'h0, v[i]});
    end
    apb(1'b1, 8'h51, 32'hFFFF);
    chk(32'(err), 32'h1);
    chk(ab_freq_word, 32'h8765_1234);
    apb(1'b0, 8'h68, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    chk(cd_freq_word, 32'h0001_FEDC);
    apb(1'b0, 8'h54, 32'h0);
    chk(rd, 32'h0000_8765);
    apb(1'b0, 8'h5C, 32'h0);
    chk(rd, 32'h0000_0001);
    $display("test_freq done");
  endtask
  task automatic test_pll;
    logic [2:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      cfg({3'h1, b[2], 1'b1, b[0], 2'h0, b[1:0], b, 3'h7}, {b[0], 7'(i == 7 ? 127 : i + 1),
        4'(i == 0 ? 0 : 2 * i + 1), b[1:0], 2'h3});
    end
    $display("test_pll done");
  endtask
  task automatic count_sync(input logic [31:0] exp);
    int n;
    n = 0;
    sync_pin <= 1'b1;
    repeat (12)
    begin
      @(posedge pclk);
      if (ndiv_sync === 1'b1)
        n++;
    end
    sync_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(n), exp);
  endtask
  task automatic test_sync;
    count_sync(32'h1);
    cfg(16'h2000, 16'h0444);
    count_sync(32'h0);
    // Live code must follow the pin, not a value latched at reset
    lf_volt_pin <= 3'h2;
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h0000_2002);
    $display("test_sync done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    summarize();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, sync_pin} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lf_volt_pin = 3'h5;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    test_reset();
    test_freq();
    test_pll();
    test_sync();
    summarize();
  end
endmodule
bind nco_pll_regs nco_pll_regs_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .lf_volt_pin(lf_volt_pin),
  .sync_pin(sync_pin), .ab_freq_word(ab_freq_word), .cd_freq_word(cd_freq_word),
  .pll_cfg(pll_cfg), .ndiv_sync(ndiv_sync));
